// ==== inc/cmr_defs.svh ====
// register offsets, field positions, error thresholds and timing counts
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH
`define CMR_OFF_CTRL  8'h00
`define CMR_OFF_CFG2  8'h04
`define CMR_OFF_INTF  8'h08
`define CMR_OFF_INTE  8'h0c
`define CMR_OFF_RXC0  8'h10
`define CMR_OFF_RXC1  8'h14
`define CMR_OFF_ERRC  8'h18
`define CMR_OFF_FILT0 8'h20
`define CMR_OFF_MASK0 8'h38
`define CMR_OFF_MASK1 8'h3c
`define CMR_OFF_RECEIVE_BUFFER_ZERO  8'h40
`define CMR_OFF_RECEIVE_BUFFER_ONE  8'h50
`define CMR_REQ_LO    8
`define CMR_STAT_LO   5
`define CMR_DOUBLE_BUFFER_ENABLE      0
`define CMR_WAKE_FILTER_ENABLE    14
`define CMR_F_RX0     0
`define CMR_F_RX1     1
`define CMR_F_ERR     5
`define CMR_F_WAK     6
`define CMR_F_IVR     7
`define CMR_F_RECEIVE_WARNING_FLAG   9
`define CMR_F_RECEIVE_ERROR_PASSIVE_FLAG    11
`define CMR_F_OVR1    14
`define CMR_F_OVR0    15
`define CMR_RXC_FULL  7
`define CMR_RXC_RXM   5
`define CMR_FEXT      30
`define CMR_BEXT      31
`define CMR_WARN      8'h60
`define CMR_PASSIVE   8'h7f
`define CMR_CLK_NS    25
`define CMR_BIT_NS    1000
`define CMR_IDLE_BITS 11
`define CMR_IDLE_CYC  ((`CMR_IDLE_BITS * `CMR_BIT_NS + `CMR_CLK_NS - 1) / `CMR_CLK_NS)
`define CMR_WFILT_NS  250
`define CMR_WFILT_CYC ((`CMR_WFILT_NS + `CMR_CLK_NS - 1) / `CMR_CLK_NS)
`endif

// ==== inc/cmr_pkg.sv ====
// types shared by the mode and receive logic
package cmr_pkg;
  // mode field codes; 2, 3 and 4 chosen for loopback, listen-only, config
  typedef enum logic [2:0] {
    CMR_NORMAL  = 3'h0,
    CMR_DISABLE = 3'h1,
    CMR_LOOP    = 3'h2,
    CMR_LISTEN  = 3'h3,
    CMR_CONFIG  = 3'h4,
    CMR_LISTALL = 3'h7
  } cmr_mode_e;
endpackage

// ==== rtl/cmr_top.sv ====
// mode control and receive path of a can controller, axi4-lite registers
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`include "cmr_defs.svh"

module cmr_top (
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        SRST_IN,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  // can pins
  input  wire logic        CAN_RX_PIN_IN,
  output logic             CAN_TX_PIN_OUT,
  output logic             CAN_TX_PIN_OE_OUT,
  output logic             CAN_RX_PIN_FN_OUT,
  // protocol engine side
  input  wire logic        TX_BIT_IN,
  input  wire logic        TX_BUSY_IN,
  input  wire logic        TX_REQUEST_IN,
  output logic             TX_HOLD_OUT,
  output logic             TX_ABORT_OUT,
  output logic             RX_BIT_OUT,
  output logic             RX_ENABLE_OUT,
  output logic             TX_ENABLE_OUT,
  output logic             PASSIVE_OUT,
  output logic             ERR_PASSIVE_OUT,
  input  wire logic        FRAME_DONE_IN,
  input  wire logic        FRAME_ERR_IN,
  input  wire logic [28:0] FRAME_ID_IN,
  input  wire logic        FRAME_EXT_IN,
  input  wire logic [3:0]  FRAME_DLC_IN,
  input  wire logic [63:0] FRAME_DATA_IN,
  // interrupt request
  output logic             IRQ_OUT
);
  localparam logic [8:0] IDLE_CYC  = 9'(`CMR_IDLE_CYC);
  localparam logic [3:0] WFILT_CYC = 4'(`CMR_WFILT_CYC);

  cmr_pkg::cmr_mode_e mode;
  logic [2:0]  req;
  logic        double_buffer_enable, wake_filter_enable;
  logic [15:0] intf, inte, set_f, clr_f;
  logic [1:0]  acceptance_mask_zero, acceptance_mask_one;
  logic        full0, full1;
  logic [30:0] filt [6];
  logic [28:0] mask [2];
  logic [29:0] bid [2];
  logic [63:0] bdat [2];
  logic [3:0]  bdlc [2];
  logic [7:0]  err_cnt, next_err_cnt;
  logic        rx_m, rx_s, rx_f, rx_f_d;
  logic [3:0]  wf_cnt;
  logic [8:0]  rec_cnt;
  logic        bus_idle, switch_now, hold, rx_line;
  logic        aw_full, w_full, do_wr;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] wd_mask;
  logic        mab_valid, mab_ext;
  logic [28:0] mab_id;
  logic [3:0]  mab_dlc;
  logic [63:0] mab_data;
  logic [5:0]  fhit;
  logic        tgt0, tgt1, store0, store1, ovr0, ovr1;
  logic        err_ev, err_inc, warn_ev, pass_ev, wake_ev, cfg_ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:2] <= `CMR_OFF_ERRC >> 2) ||
           (a[7:2] >= `CMR_OFF_FILT0 >> 2 && a[7:2] <= `CMR_OFF_MASK1 >> 2) ||
           (a[7:2] >= `CMR_OFF_RECEIVE_BUFFER_ZERO >> 2 && a[7:2] <= 6'h16 && a[3:2] != 2'h3);
  endfunction

  // std frames compare the low 11 id bits only
  function automatic logic fmatch(input logic [28:0] id, input logic ext,
                                  input logic [30:0] f, input logic [28:0] m,
                                  input logic [1:0] receive_mask_mode);
    logic        sel;
    logic [28:0] cm;
    cm = ext ? m : {18'h0, m[10:0]};
    unique case (receive_mask_mode)
      2'h1:    sel = !ext;
      2'h2:    sel = ext;
      2'h3:    sel = 1'b1;
      default: sel = (f[`CMR_FEXT] == ext);
    endcase
    return (receive_mask_mode == 2'h3) || (sel && (((id ^ f[28:0]) & cm) == 29'h0));
  endfunction

  // pin synchroniser and wake filter
  always_ff @(posedge CLOCK_IN)
  begin
    rx_m <= SRST_IN ? 1'b1 : CAN_RX_PIN_IN;
    rx_s <= SRST_IN ? 1'b1 : rx_m;
  end

  // filter only while asleep, so normal bit timing sees no extra delay
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      rx_f   <= 1'b1;
      rx_f_d <= 1'b1;
      wf_cnt <= 4'h0;
    end
    else
    begin
      rx_f_d <= rx_f;
      if (!(wake_filter_enable && mode == cmr_pkg::CMR_DISABLE) || rx_s == rx_f)
      begin
        rx_f   <= rx_s;
        wf_cnt <= 4'h0;
      end
      else if (wf_cnt == WFILT_CYC - 4'h1)
      begin
        rx_f   <= rx_s;
        wf_cnt <= 4'h0;
      end
      else
        wf_cnt <= wf_cnt + 4'h1;
    end
  end

  assign rx_line    = (mode == cmr_pkg::CMR_LOOP) ? TX_BIT_IN : rx_f;
  assign RX_BIT_OUT = rx_line;
  assign wake_ev    = mode == cmr_pkg::CMR_DISABLE && rx_f_d && !rx_f;

  // idle detect, restarted on every mode switch
  assign bus_idle   = rec_cnt == IDLE_CYC;
  assign switch_now = req != mode && bus_idle && req != 3'h5 && req != 3'h6
                      && !(req == cmr_pkg::CMR_CONFIG && TX_BUSY_IN);

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || switch_now || !rx_line)
      rec_cnt <= 9'h0;
    else if (!bus_idle)
      rec_cnt <= rec_cnt + 9'h1;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      mode <= cmr_pkg::CMR_CONFIG;
    else if (switch_now)
      mode <= cmr_pkg::cmr_mode_e'(req);
  end

  // post-entry wait before a transmitting mode may send
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      hold         <= 1'b0;
      TX_ABORT_OUT <= 1'b0;
    end
    else
    begin
      if (switch_now)
        hold <= req == cmr_pkg::CMR_NORMAL || req == cmr_pkg::CMR_LOOP ||
                req == cmr_pkg::CMR_LISTALL;
      else if (bus_idle)
        hold <= 1'b0;
      TX_ABORT_OUT <= hold && TX_REQUEST_IN && req == cmr_pkg::CMR_DISABLE;
    end
  end

  // pin functions and engine enables
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      CAN_TX_PIN_OUT    <= 1'b1;
      CAN_TX_PIN_OE_OUT <= 1'b0;
      CAN_RX_PIN_FN_OUT <= 1'b0;
    end
    else
    begin
      CAN_TX_PIN_OE_OUT <= mode == cmr_pkg::CMR_NORMAL || mode == cmr_pkg::CMR_LISTALL;
      CAN_TX_PIN_OUT    <= (mode == cmr_pkg::CMR_NORMAL || mode == cmr_pkg::CMR_LISTALL)
                           ? TX_BIT_IN : 1'b1;
      CAN_RX_PIN_FN_OUT <= mode == cmr_pkg::CMR_NORMAL || mode == cmr_pkg::CMR_LISTEN ||
                           mode == cmr_pkg::CMR_LISTALL;
    end
  end

  assign RX_ENABLE_OUT = mode != cmr_pkg::CMR_CONFIG && mode != cmr_pkg::CMR_DISABLE;
  assign TX_ENABLE_OUT = RX_ENABLE_OUT && mode != cmr_pkg::CMR_LISTEN && !hold;
  assign PASSIVE_OUT   = mode == cmr_pkg::CMR_LISTEN;
  assign TX_HOLD_OUT   = hold;

  // assembly buffer; listen-all also keeps a frame cut short by an error
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      mab_valid <= 1'b0;
    else
      mab_valid <= RX_ENABLE_OUT && (FRAME_DONE_IN ||
                   (FRAME_ERR_IN && mode == cmr_pkg::CMR_LISTALL));
  end

  always_ff @(posedge CLOCK_IN)
  begin
    mab_id   <= FRAME_ID_IN;
    mab_ext  <= FRAME_EXT_IN;
    mab_dlc  <= FRAME_DLC_IN;
    mab_data <= FRAME_DATA_IN;
  end

  for (genvar i = 0; i < 6; i++)
  begin : g_filt
    assign fhit[i] = (i < 2) ? fmatch(mab_id, mab_ext, filt[i], mask[0], acceptance_mask_zero)
                             : fmatch(mab_id, mab_ext, filt[i], mask[1], acceptance_mask_one);
  end

  assign tgt0   = mab_valid && (mode == cmr_pkg::CMR_LISTALL || |fhit[1:0]);
  assign tgt1   = mab_valid && !tgt0 && |fhit[5:2];
  assign store0 = tgt0 && !full0;
  assign store1 = (tgt1 && !full1) || (tgt0 && full0 && double_buffer_enable && !full1);
  assign ovr0   = tgt0 && full0 && !double_buffer_enable;
  assign ovr1   = (tgt1 && full1) || (tgt0 && full0 && double_buffer_enable && full1);

  always_ff @(posedge CLOCK_IN)
  begin
    if (store0)
    begin
      bid[0]  <= {mab_ext, mab_id};
      bdat[0] <= mab_data;
      bdlc[0] <= mab_dlc;
    end
    if (store1)
    begin
      bid[1]  <= {mab_ext, mab_id};
      bdat[1] <= mab_data;
      bdlc[1] <= mab_dlc;
    end
  end

  // receive error counter
  assign err_ev       = FRAME_ERR_IN && RX_ENABLE_OUT && mode != cmr_pkg::CMR_LISTALL;
  assign err_inc      = err_ev && mode != cmr_pkg::CMR_LISTEN;
  assign next_err_cnt = (err_cnt == 8'hff) ? err_cnt : err_cnt + 8'h1;
  assign warn_ev      = err_inc && next_err_cnt == `CMR_WARN && err_cnt != `CMR_WARN;
  assign pass_ev      = err_inc && next_err_cnt == `CMR_PASSIVE + 8'h1;

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || mode == cmr_pkg::CMR_CONFIG)
      err_cnt <= 8'h0;
    else if (err_inc)
      err_cnt <= next_err_cnt;
  end

  assign ERR_PASSIVE_OUT = err_cnt > `CMR_PASSIVE;

  // axi4-lite write path
  assign S_AXI_AWREADY_OUT = !aw_full;
  assign S_AXI_WREADY_OUT  = !w_full;
  assign do_wr   = aw_full && w_full && !S_AXI_BVALID_OUT;
  assign cfg_ok  = mode == cmr_pkg::CMR_CONFIG;
  assign wd_mask = merge(32'h0, 32'hffffffff, w_strb);

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      aw_full          <= 1'b0;
      w_full           <= 1'b0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= 2'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      else if (do_wr)
        aw_full <= 1'b0;
      if (S_AXI_WVALID_IN && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
      end
      else if (do_wr)
        w_full <= 1'b0;
      if (do_wr)
      begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= mapped(aw_addr) ? 2'h0 : 2'h3;
      end
      else if (S_AXI_BREADY_IN)
        S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // control and configuration registers
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      req    <= cmr_pkg::CMR_CONFIG;
      double_buffer_enable   <= 1'b0;
      wake_filter_enable <= 1'b0;
      inte   <= 16'h0;
      acceptance_mask_zero   <= 2'h0;
      acceptance_mask_one   <= 2'h0;
      mask   <= '{default: 29'h0};
      filt   <= '{default: 31'h0};
    end
    else if (do_wr)
    begin
      if (hit(aw_addr, `CMR_OFF_CTRL))
      begin
        if (w_strb[1])
          req <= w_data[`CMR_REQ_LO +: 3];
        if (cfg_ok && w_strb[0])
          double_buffer_enable <= w_data[`CMR_DOUBLE_BUFFER_ENABLE];
      end
      if (cfg_ok && w_strb[1] && hit(aw_addr, `CMR_OFF_CFG2))
        wake_filter_enable <= w_data[`CMR_WAKE_FILTER_ENABLE];
      if (cfg_ok && hit(aw_addr, `CMR_OFF_INTE))
        inte <= 16'(merge({16'h0, inte}, w_data, w_strb));
      if (cfg_ok && w_strb[0] && hit(aw_addr, `CMR_OFF_RXC0))
        acceptance_mask_zero <= w_data[`CMR_RXC_RXM +: 2];
      if (cfg_ok && w_strb[0] && hit(aw_addr, `CMR_OFF_RXC1))
        acceptance_mask_one <= w_data[`CMR_RXC_RXM +: 2];
      for (int k = 0; k < 6; k++)
      begin
        if (cfg_ok && hit(aw_addr, `CMR_OFF_FILT0 + 8'(4 * k)))
          filt[k] <= 31'(merge({1'b0, filt[k]}, w_data, w_strb));
      end
      if (cfg_ok && hit(aw_addr, `CMR_OFF_MASK0))
        mask[0] <= 29'(merge({3'h0, mask[0]}, w_data, w_strb));
      if (cfg_ok && hit(aw_addr, `CMR_OFF_MASK1))
        mask[1] <= 29'(merge({3'h0, mask[1]}, w_data, w_strb));
    end
  end

  // sticky flags: hardware set beats a same-cycle software clear
  always_comb
  begin
    set_f = 16'h0;
    set_f[`CMR_F_RX0]   = store0;
    set_f[`CMR_F_RX1]   = store1;
    set_f[`CMR_F_OVR0]  = ovr0;
    set_f[`CMR_F_OVR1]  = ovr1;
    set_f[`CMR_F_ERR]   = ovr0 || ovr1 || pass_ev;
    set_f[`CMR_F_WAK]   = wake_ev;
    set_f[`CMR_F_IVR]   = err_ev;
    set_f[`CMR_F_RECEIVE_WARNING_FLAG] = warn_ev;
    set_f[`CMR_F_RECEIVE_ERROR_PASSIVE_FLAG]  = pass_ev;
    clr_f = (do_wr && hit(aw_addr, `CMR_OFF_INTF)) ? w_data[15:0] & wd_mask[15:0] : 16'h0;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      intf    <= 16'h0;
      full0   <= 1'b0;
      full1   <= 1'b0;
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      intf    <= (intf & ~clr_f) | set_f;
      full0   <= store0 || (full0 && !rel0());
      full1   <= store1 || (full1 && !rel1());
      IRQ_OUT <= |(intf & inte);
    end
  end

  // buffer release: writing a one to the full bit
  function automatic logic rel0();
    return do_wr && hit(aw_addr, `CMR_OFF_RXC0) && w_strb[0] && w_data[`CMR_RXC_FULL];
  endfunction

  function automatic logic rel1();
    return do_wr && hit(aw_addr, `CMR_OFF_RXC1) && w_strb[0] && w_data[`CMR_RXC_FULL];
  endfunction

  // axi4-lite read path
  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h0;
      S_AXI_RRESP_OUT  <= 2'h0;
    end
    else if (S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT)
    begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT  <= mapped(S_AXI_ARADDR_IN) ? 2'h0 : 2'h3;
      S_AXI_RDATA_OUT  <= rd_mux(S_AXI_ARADDR_IN);
    end
    else if (S_AXI_RREADY_IN)
      S_AXI_RVALID_OUT <= 1'b0;
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a[7:2])
      6'h00: r = {21'h0, req, mode, 4'h0, double_buffer_enable};
      6'h01: r = 32'(wake_filter_enable) << `CMR_WAKE_FILTER_ENABLE;
      6'h02: r = {16'h0, intf};
      6'h03: r = {16'h0, inte};
      6'h04: r = {24'h0, full0, acceptance_mask_zero, 1'b0, bdlc[0]};
      6'h05: r = {24'h0, full1, acceptance_mask_one, 1'b0, bdlc[1]};
      6'h06: r = {24'h0, err_cnt};
      6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d: r = {1'b0, filt[a[4:2]]};
      6'h0e: r = {3'h0, mask[0]};
      6'h0f: r = {3'h0, mask[1]};
      6'h10, 6'h14: r = {bid[a[2+2]][29], 2'h0, bid[a[4]][28:0]};
      6'h11, 6'h15: r = bdat[a[4]][31:0];
      6'h12, 6'h16: r = bdat[a[4]][63:32];
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // checks
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (SRST_IN);

  sequence enter_tx_s;
    switch_now && req == cmr_pkg::CMR_NORMAL;
  endsequence

  mode_idle_a: assert property ($changed(mode) |-> $past(bus_idle))
    else $error("mode changed on a busy bus");
  cfg_busy_a: assert property (switch_now && req == cmr_pkg::CMR_CONFIG |-> !TX_BUSY_IN)
    else $error("config entered during transmission");
  init_clear_a: assert property (mode == cmr_pkg::CMR_CONFIG |=> err_cnt == 8'h0)
    else $error("error counter not cleared in config mode");
  listen_frz_a: assert property ((mode == cmr_pkg::CMR_LISTEN)[*2] |-> $stable(err_cnt))
    else $error("error counter moved in listen-only");
  loop_route_a: assert property (mode == cmr_pkg::CMR_LOOP |-> RX_BIT_OUT == TX_BIT_IN)
    else $error("loopback not routed");
  tx_hold_a: assert property (enter_tx_s |=> (hold && !TX_ENABLE_OUT) [*3])
    else $error("no 11-bit wait after entry");
  abort_tx_a: assert property (hold && TX_REQUEST_IN && req == cmr_pkg::CMR_DISABLE
                               |=> TX_ABORT_OUT)
    else $error("pending transmit not aborted");
  store_flag_a: assert property (store0 |=> intf[`CMR_F_RX0] && full0)
    else $error("buffer zero store not flagged");
  ovr_flag_a: assert property (ovr0 |=> intf[`CMR_F_OVR0] && intf[`CMR_F_ERR])
    else $error("overrun not flagged");
  double_buffer_enable_spill_a: assert property (tgt0 && full0 && double_buffer_enable && !full1 |=> full1 && !$past(ovr0))
    else $error("double buffer spill failed");
  warn_flag_a: assert property (err_inc && err_cnt == 8'h5f |=> intf[`CMR_F_RECEIVE_WARNING_FLAG])
    else $error("warning not flagged at 96");
  pass_flag_a: assert property (err_inc && err_cnt == 8'h7f |=> ERR_PASSIVE_OUT
                                && intf[`CMR_F_RECEIVE_ERROR_PASSIVE_FLAG] && intf[`CMR_F_ERR])
    else $error("error passive not flagged");
endmodule

// ==== rtl/cmr_unused_guard.sv ====
// no logic here: the whole block sits in cmr_top

// ==== test/cmr_bus_model.sv ====
// bus-side model: receive line activity and finished-frame reports
module cmr_bus_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // frame request from the bench
  input  wire logic        go_in,
  input  wire logic        err_in,
  input  wire logic        ext_in,
  input  wire logic [28:0] id_in,
  // toward the controller
  output logic             rx_out,
  output logic             done_out,
  output logic             ferr_out,
  output logic [28:0]      id_out,
  output logic             ext_out,
  output logic [3:0]       dlc_out,
  output logic [63:0]      data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt;
  always_ff @(posedge clk_in)
  begin
    done_out <= 1'b0;
    ferr_out <= 1'b0;
    // payload is only valid with the pulse, scrambled otherwise
    id_out   <= ~id_out;
    ext_out  <= ~ext_out;
    dlc_out  <= ~dlc_out;
    data_out <= ~data_out;
    if (rst_in)
    begin
      cnt    <= 3'h0;
      rx_out <= 1'b1;
      id_out <= 29'h0;
      ext_out <= 1'b0;
      dlc_out <= 4'h0;
      data_out <= 64'h0;
    end
    else if (go_in)
    begin
      cnt    <= 3'h4;
      rx_out <= 1'b0;
    end
    else if (cnt != 3'h0)
    begin
      cnt    <= cnt - 3'h1;
      rx_out <= cnt[0];
      if (cnt == 3'h1)
      begin
        done_out <= ~err_in;
        ferr_out <= err_in;
        id_out   <= id_in;
        ext_out  <= ext_in;
        dlc_out  <= 4'h8;
        data_out <= {id_in, 3'h0, id_in, 3'h1};
      end
    end
  end
endmodule

// ==== test/cmr_top_tb.sv ====
// self-checking bench for the can mode and receive block
`include "cmr_defs.svh"
module cmr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLOCK_IN, SRST_IN, S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT, S_AXI_WVALID_IN;
  logic        S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_BREADY_IN, S_AXI_ARVALID_IN;
  logic        S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, S_AXI_RREADY_IN, CAN_RX_PIN_IN;
  logic        CAN_TX_PIN_OUT, CAN_TX_PIN_OE_OUT, RX_ENABLE_OUT, PASSIVE_OUT;
  logic        ERR_PASSIVE_OUT, FRAME_DONE_IN, FRAME_ERR_IN, FRAME_EXT_IN, IRQ_OUT;
  logic        bus_rx, go, f_err, f_ext;
  logic        tx_busy, tx_req, db, TX_ABORT_OUT, TX_HOLD_OUT, TX_ENABLE_OUT;
  logic        CAN_RX_PIN_FN_OUT;
  logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rsp;
  logic [7:0]  S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
  logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT, rdv, seed, fid, ff, v;
  logic [28:0] FRAME_ID_IN;
  logic [3:0]  FRAME_DLC_IN;
  logic [63:0] FRAME_DATA_IN;
  logic [4:0][2:0] mc;
  logic [4:0][3:0] pins;
  int          err_count, n_tests, i;

  // wired-and bus: our driver only pulls when it owns the pin
  assign CAN_RX_PIN_IN = bus_rx & (CAN_TX_PIN_OE_OUT ? CAN_TX_PIN_OUT : 1'b1);

  initial
  begin
    CLOCK_IN = 1'b0;
    forever #12.5 CLOCK_IN = ~CLOCK_IN;
  end

  cmr_top dut_u (
    .CLOCK_IN, .SRST_IN, .S_AXI_AWADDR_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
    .S_AXI_WDATA_IN, .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
    .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN,
    .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT,
    .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .CAN_RX_PIN_IN, .CAN_TX_PIN_OUT,
    .CAN_TX_PIN_OE_OUT, .CAN_RX_PIN_FN_OUT, .TX_BIT_IN(1'b1), .TX_BUSY_IN(tx_busy),
    .TX_REQUEST_IN(tx_req), .TX_HOLD_OUT, .TX_ABORT_OUT, .RX_BIT_OUT(),
    .RX_ENABLE_OUT, .TX_ENABLE_OUT, .PASSIVE_OUT, .ERR_PASSIVE_OUT, .FRAME_DONE_IN,
    .FRAME_ERR_IN, .FRAME_ID_IN, .FRAME_EXT_IN, .FRAME_DLC_IN, .FRAME_DATA_IN, .IRQ_OUT
  );

  cmr_bus_model bus_u (
    .clk_in(CLOCK_IN), .rst_in(SRST_IN), .go_in(go), .err_in(f_err), .ext_in(f_ext),
    .id_in(fid[28:0]), .rx_out(bus_rx), .done_out(FRAME_DONE_IN),
    .ferr_out(FRAME_ERR_IN), .id_out(FRAME_ID_IN), .ext_out(FRAME_EXT_IN),
    .dlc_out(FRAME_DLC_IN), .data_out(FRAME_DATA_IN)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic summarize;
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic lost;
    err_count++;
    $display("[FAIL] %0t bus wait expired", $time);
    summarize();
  endtask

  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= d;
    S_AXI_AWVALID_IN <= 1'b1;
    S_AXI_WVALID_IN <= 1'b1;
    S_AXI_BREADY_IN <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge CLOCK_IN);
      if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'b0;
      if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'b0;
      if (S_AXI_BVALID_OUT) break;
    end
    rsp = S_AXI_BRESP_OUT;
    S_AXI_BREADY_IN <= 1'b0;
    if (n == 50) lost();
    @(posedge CLOCK_IN);
  endtask

  task automatic rd_t(input logic [7:0] a, output logic [31:0] d);
    int n;
    S_AXI_ARADDR_IN <= a;
    S_AXI_ARVALID_IN <= 1'b1;
    S_AXI_RREADY_IN <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge CLOCK_IN);
      if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'b0;
      if (S_AXI_RVALID_OUT) break;
    end
    d = S_AXI_RDATA_OUT;
    rsp = S_AXI_RRESP_OUT;
    S_AXI_RREADY_IN <= 1'b0;
    if (n == 50) lost();
    @(posedge CLOCK_IN);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    rd_t(a, rdv);
    chk(rdv & m, e);
  endtask

  // software polls the status field for the acknowledged mode
  task automatic md(input logic [2:0] c);
    int n;
    wr(`CMR_OFF_CTRL, {21'h0, c, 7'h0, db});
    rdv = {24'h0, ~c, 5'h0};
    for (n = 0; n < 300 && rdv[7:5] !== c; n++)
      rd_t(`CMR_OFF_CTRL, rdv);
    chk({29'h0, rdv[7:5]}, {29'h0, c});
  endtask

  task automatic fr(input logic [31:0] id, input logic e, x);
    fid <= id;
    f_err <= e;
    f_ext <= x;
    go <= 1'b1;
    @(posedge CLOCK_IN);
    go <= 1'b0;
    repeat (10) @(posedge CLOCK_IN);
  endtask

  initial
  begin
    err_count = 0;
    n_tests = 0;
    seed = 32'h7de541cf;
    SRST_IN = 1'b1;
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN} = 3'h0;
    {S_AXI_ARVALID_IN, S_AXI_RREADY_IN, go, f_err, f_ext, tx_busy, tx_req, db} = 8'h0;
    {S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, S_AXI_WDATA_IN, fid} = 80'h0;
    mc = {3'h0, 3'h7, 3'h3, 3'h2, 3'h1};
    pins = {4'he, 4'he, 4'hb, 4'h2, 4'h0};
    repeat (20) @(posedge CLOCK_IN);
    SRST_IN <= 1'b0;
    rc(`CMR_OFF_CTRL, 32'h7e0, 32'h480);
    seed = xs(seed);
    ff = {21'h0, 1'b0, seed[9:0]};
    wr(`CMR_OFF_FILT0, ff);
    wr(`CMR_OFF_MASK0, 32'h7f0);
    wr(`CMR_OFF_INTE, 32'h23);
    rc(`CMR_OFF_FILT0, 32'h7fffffff, ff);
    rc(8'h7c, 32'hffffffff, 32'h0);
    chk(32'(rsp), 32'h3);
    wr(`CMR_OFF_FILT0 + 8'hc, 32'h0);
    chk(32'(rsp), 32'h0);
    wr(`CMR_OFF_CTRL, 32'h0);
    rc(`CMR_OFF_CTRL, 32'he0, 32'h80);
    md(3'h0);
    chk(32'({TX_HOLD_OUT, TX_ENABLE_OUT}), 32'h2);
    tx_req <= 1'b1;
    wr(`CMR_OFF_CTRL, 32'h100);
    chk(32'(TX_ABORT_OUT), 32'h1);
    tx_req <= 1'b0;
    wr(`CMR_OFF_CTRL, 32'h0);
    wr(`CMR_OFF_FILT0, ~ff);
    rc(`CMR_OFF_FILT0, 32'h7fffffff, ff);
    seed = xs(seed);
    v = ff ^ {28'h0, seed[3:0]};
    fr(v, 1'b0, 1'b0);
    rc(`CMR_OFF_RXC0, 32'h80, 32'h80);
    rc(`CMR_OFF_RECEIVE_BUFFER_ZERO, 32'hffffffff, v);
    rc(`CMR_OFF_RECEIVE_BUFFER_ZERO + 8'h4, 32'hffffffff, {v[28:0], 3'h1});
    rc(`CMR_OFF_INTF, 32'h1, 32'h1);
    chk(32'(IRQ_OUT), 32'h1);
    fr(v ^ 32'h1, 1'b0, 1'b0);
    rc(`CMR_OFF_INTF, 32'hc023, 32'h8021);
    rc(`CMR_OFF_RECEIVE_BUFFER_ZERO, 32'hffffffff, v);
    fr(v ^ 32'h400, 1'b0, 1'b0);
    rc(`CMR_OFF_RXC1, 32'h80, 32'h80);
    rc(`CMR_OFF_RECEIVE_BUFFER_ONE, 32'hffffffff, v ^ 32'h400);
    fr(32'h1abcdef, 1'b0, 1'b1);
    rc(`CMR_OFF_INTF, 32'h4000, 32'h0);
    wr(`CMR_OFF_INTF, 32'hffff);
    rc(`CMR_OFF_INTF, 32'hffff, 32'h0);
    for (i = 0; i < 95; i++)
      fr(xs(i), 1'b1, 1'b0);
    rc(`CMR_OFF_ERRC, 32'hff, 32'd95);
    rc(`CMR_OFF_INTF, 32'h2a0, 32'h80);
    fr(32'h5, 1'b1, 1'b0);
    rc(`CMR_OFF_INTF, 32'h280, 32'h280);
    for (i = 0; i < 31; i++)
      fr(xs(i), 1'b1, 1'b0);
    rc(`CMR_OFF_INTF, 32'h800, 32'h0);
    fr(32'h9, 1'b1, 1'b0);
    rc(`CMR_OFF_ERRC, 32'hff, 32'd128);
    rc(`CMR_OFF_INTF, 32'h820, 32'h820);
    chk(32'(ERR_PASSIVE_OUT), 32'h1);
    tx_busy <= 1'b1;
    wr(`CMR_OFF_CTRL, 32'h400);
    repeat (500) @(posedge CLOCK_IN);
    rc(`CMR_OFF_CTRL, 32'he0, 32'h0);
    tx_busy <= 1'b0;
    md(3'h4);
    rc(`CMR_OFF_ERRC, 32'hff, 32'h0);
    rc(`CMR_OFF_INTF, 32'h880, 32'h880);
    // release buffer one, then spill and overrun with double buffering on
    wr(`CMR_OFF_RXC1, 32'h80);
    db = 1'b1;
    md(3'h0);
    fr(v, 1'b0, 1'b0);
    rc(`CMR_OFF_INTF, 32'hc000, 32'h0);
    rc(`CMR_OFF_RECEIVE_BUFFER_ONE, 32'hffffffff, v);
    fr(v, 1'b0, 1'b0);
    rc(`CMR_OFF_INTF, 32'hc000, 32'h4000);
    for (i = 0; i < 5; i++)
    begin
      md(mc[i]);
      v = 32'({CAN_RX_PIN_FN_OUT, CAN_TX_PIN_OE_OUT, RX_ENABLE_OUT, PASSIVE_OUT});
      chk(v, 32'(pins[i]));
      if (i == 0)
      begin
        fr(32'h0, 1'b0, 1'b0);
        rc(`CMR_OFF_INTF, 32'h41, 32'h40);
      end
    end
    summarize();
  end
endmodule
